// *** src/led_ind_regs.svh ***
`ifndef LED_IND_REGS_SVH
`define LED_IND_REGS_SVH

// register byte offsets
`define OFS_CTRL 4'h0
`define OFS_BLINK 4'h4
`define OFS_SPEED 4'h8
`define OFS_STATUS 4'hc
// ctrl field positions
`define CTRL_DUAL 0
`define CTRL_STARTUP_DONE 1
// reset values
`define BLINK_RST 32'h05f5e100
`define SPEED_RST 16'h0000
`define CTRL_DUAL_RST 1'b0
`define CTRL_STARTUP_RST 1'b0
// real-time delay after start-up, seconds, and clock rate
`define RT_DELAY_S 10
`define CLK_HZ 200000000
`define RT_CYCLES (`RT_DELAY_S * `CLK_HZ)
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** src/led_ind_pkg.sv ***
`default_nettype none
package led_ind_pkg;
   // led colour code
   typedef enum logic [1:0] {
      col_off,
      col_red,
      col_green,
      col_orange
   } colour_type;

   // navigator progression
   typedef enum logic [2:0] {
      nav_boot,
      nav_no_fix,
      nav_time_lock,
      nav_ready,
      nav_init,
      nav_realtime
   } nav_state_type;

   // receiver solution quality
   typedef enum logic [2:0] {
      sol_none,
      sol_standalone,
      sol_differential,
      sol_float,
      sol_integer
   } sol_type;
endpackage
`default_nettype wire

// *** src/nav_status_led_indicator.sv ***
// Functional notes
// RQ1 - navigator led dark until program runs
// RQ2 - sleep lock alternates red and green
// RQ3 - running without fix blinks red
// RQ4 - internal time lock blinks orange
// RQ5 - external fix gives steady red ready
// RQ6 - initialise only above speed threshold
// RQ7 - initialised not realtime gives steady orange
// RQ8 - realtime navigator gives steady green
// RQ9 - green state is never left
// RQ10 - antenna config selects position or heading
// RQ11 - single antenna dark without receiver data
// RQ12 - single antenna start-up data blinks red
// RQ13 - standalone fix gives steady red
// RQ14 - differential or float fix gives orange
// RQ15 - integer fix gives green
// RQ16 - dual antenna dark signals receiver fault
// RQ17 - dual antenna no heading blinks red
// RQ18 - differential heading gives steady red
// RQ19 - float heading gives orange
// RQ20 - integer heading gives green
// RQ21 - power led green with 5 V good
// RQ22 - power led orange while transmitting
// RQ23 - one programmable blink period for all
// RQ24 - sleep wins, states advance in order
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "led_ind_regs.svh"
`default_nettype none

module nav_status_led_indicator
   import led_ind_pkg::*;
#(
   parameter logic [31:0] rt_cycles = `RT_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // status inputs
   input wire logic program_running,
   input wire logic sleep_locked,
   input wire logic int_time_lock,
   input wire logic ext_pos_vel_valid,
   input wire logic [15:0] vehicle_speed,
   input wire logic rx_data_active,
   input wire logic [2:0] pos_solution,
   input wire logic [2:0] head_solution,
   input wire logic supply_5v_good,
   input wire logic primary_serial_connector_tx,
   // led drives
   output logic [1:0] navigator_state_led,
   output logic [1:0] solution_led,
   output logic [1:0] power_led
);

   logic [31:0] blink_period_q;
   logic [15:0] init_speed_q;
   logic dual_antenna_q;
   logic startup_done_q;
   logic [31:0] blink_cnt_q;
   logic blink_phase_q;
   logic [31:0] rt_cnt_q;
   logic rt_done_q;
   nav_state_type nav_q;
   nav_state_type nav_d;
   colour_type nav_col_d;
   colour_type sol_col_d;
   colour_type pwr_col_d;
   logic [31:0] rdata_d;
   logic rd_ok_d;
   logic wr_go;
   logic wr_hit;
   logic sleep_shown;
   logic fast_enough;
   logic rt_last;
   logic half_done;
   colour_type pos_col_d;
   colour_type head_col_d;

   // byte-lane merge used by the blink and speed registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // colour for the lit half of a flash; the other half stays dark
   function automatic colour_type flash(input colour_type lit, input logic phase);
      colour_type c;
      c = col_off;
      if (phase) begin
         c = lit;
      end
      return c;
   endfunction

   // write decode; status is read-only, so only the three settings match
   function automatic logic wr_mapped(input logic [3:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (addr)
         `OFS_CTRL, `OFS_BLINK, `OFS_SPEED: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // read decode; every writable word reads back, plus the status word
   function automatic logic rd_mapped(input logic [3:0] addr);
      logic hit;
      hit = wr_mapped(addr);
      if (addr == `OFS_STATUS) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // last cycle of a half period; a period under two flips every clock
   // rather than never, so the counter cannot stall on a bad setting
   function automatic logic half_end(input logic [31:0] cnt, input logic [31:0] period);
      logic [31:0] half;
      half = period >> 1;
      return (cnt + 32'h0000_0001) >= half;
   endfunction

   // status word: navigator state, solution and power led colours, real-time flag
   function automatic logic [31:0] status_word(input nav_state_type st,
                                               input logic [1:0] sol,
                                               input logic [1:0] pwr,
                                               input logic rt);
      return {24'h00_0000, rt, pwr, sol, st};
   endfunction

   // write address and data are taken together; response held until bready
   // unmapped and read-only offsets answer slverr and change nothing
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign wr_hit = wr_mapped(s_axi_awaddr);
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !s_axi_rvalid;

   // lock state is only known once the program runs, so boot stays dark
   assign sleep_shown = sleep_locked && (nav_q != nav_boot); // see RQ24

   // strictly above the threshold: a vehicle at exactly that speed waits
   assign fast_enough = vehicle_speed > init_speed_q; // see RQ6

   // last count of the start-up delay, in whole clocks from program start
   assign rt_last = rt_cnt_q >= (rt_cycles - 32'h0000_0001);

   // a smaller period written mid-count wraps at once rather than late
   assign half_done = half_end(blink_cnt_q, blink_period_q);

   // response stands until bready; no second write is taken meanwhile
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // writable configuration registers
   // ctrl takes lane zero only; blink and speed honour every strobe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_period_q <= `BLINK_RST;
         init_speed_q <= `SPEED_RST;
         dual_antenna_q <= `CTRL_DUAL_RST;
         startup_done_q <= `CTRL_STARTUP_RST;
      end else if (wr_go) begin
         unique case (s_axi_awaddr)
            `OFS_CTRL: begin
               if (s_axi_wstrb[0]) begin
                  dual_antenna_q <= s_axi_wdata[`CTRL_DUAL];
                  startup_done_q <= s_axi_wdata[`CTRL_STARTUP_DONE];
               end
            end
            `OFS_BLINK: blink_period_q <= merge(blink_period_q, s_axi_wdata, s_axi_wstrb);
            `OFS_SPEED: init_speed_q <= 16'(merge({16'h0000, init_speed_q}, s_axi_wdata,
                                                 s_axi_wstrb));
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses answer slverr with zero data
   always_comb begin
      rdata_d = 32'h0000_0000;
      rd_ok_d = rd_mapped(s_axi_araddr);
      unique case (s_axi_araddr)
         `OFS_CTRL: rdata_d = {30'h0, startup_done_q, dual_antenna_q};
         `OFS_BLINK: rdata_d = blink_period_q;
         `OFS_SPEED: rdata_d = {16'h0000, init_speed_q};
         // status is live; reading it has no side effect
         `OFS_STATUS: rdata_d = status_word(nav_q, solution_led, power_led, rt_done_q);
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // read data latched on acceptance and held while rvalid waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rd_ok_d ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // shared blink generator; phase flips every half period
   // phase starts dark after reset, so the first half period after reset is unlit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_phase_q <= 1'b0;
      end else if (half_done) begin // see RQ23
         blink_cnt_q <= 32'h0000_0000;
         blink_phase_q <= !blink_phase_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
   end

   // real-time timer runs from program start
   // counting stops once the flag is up and only reset clears the flag,
   // so the delay is paid once per reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rt_cnt_q <= 32'h0000_0000;
         rt_done_q <= 1'b0;
      end else if (program_running && !rt_done_q) begin
         if (rt_last) begin
            rt_done_q <= 1'b1; // see RQ7
         end else begin
            rt_cnt_q <= rt_cnt_q + 32'h0000_0001;
         end
      end
   end

   // navigator progression, one step at a time
   // flags that arrive together still walk every state in order
   always_comb begin
      nav_d = nav_q;
      unique case (nav_q)
         nav_boot: if (program_running) nav_d = nav_no_fix; // see RQ1
         nav_no_fix: if (int_time_lock) nav_d = nav_time_lock; // see RQ24
         nav_time_lock: if (ext_pos_vel_valid) nav_d = nav_ready;
         nav_ready: if (fast_enough) nav_d = nav_init; // see RQ6
         nav_init: if (rt_done_q) nav_d = nav_realtime;
         nav_realtime: nav_d = nav_realtime; // see RQ9
         default: nav_d = nav_boot;
      endcase
   end

   // state register; reset always returns to boot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nav_q <= nav_boot;
      end else begin
         nav_q <= nav_d;
      end
   end

   // navigator led colour; sleep overrides every state but boot
   always_comb begin
      nav_col_d = col_off;
      if (sleep_shown) begin
         // red and green swap on each half period of the shared blink
         nav_col_d = blink_phase_q ? col_green : col_red; // see RQ2
      end else begin
         unique case (nav_q)
            nav_boot: nav_col_d = col_off; // see RQ1
            nav_no_fix: nav_col_d = flash(col_red, blink_phase_q); // see RQ3
            nav_time_lock: nav_col_d = flash(col_orange, blink_phase_q); // see RQ4
            nav_ready: nav_col_d = col_red; // see RQ5
            nav_init: nav_col_d = col_orange; // see RQ7
            nav_realtime: nav_col_d = col_green; // see RQ8
            default: nav_col_d = col_off;
         endcase
      end
   end

   // single-antenna build: position fix quality
   always_comb begin
      pos_col_d = col_off;
      unique case (pos_solution)
         sol_standalone: pos_col_d = col_red; // see RQ13
         sol_differential, sol_float: pos_col_d = col_orange; // see RQ14
         sol_integer: pos_col_d = col_green; // see RQ15
         // health flash only while start-up runs, dark once it is over
         default: pos_col_d = startup_done_q ? col_off
                                             : flash(col_red, blink_phase_q); // see RQ12
      endcase
   end

   // dual-antenna build: heading lock quality
   always_comb begin
      head_col_d = col_off;
      unique case (head_solution)
         sol_differential: head_col_d = col_red; // see RQ18
         sol_float: head_col_d = col_orange; // see RQ19
         sol_integer: head_col_d = col_green; // see RQ20
         default: head_col_d = flash(col_red, blink_phase_q); // see RQ17
      endcase
   end

   // solution led: a silent receiver darkens either build
   always_comb begin
      sol_col_d = col_off;
      if (!rx_data_active) begin
         // in dual builds this dark means a fault, whatever the start-up flag
         sol_col_d = col_off; // see RQ11 RQ16
      end else if (dual_antenna_q) begin
         sol_col_d = head_col_d; // see RQ10
      end else begin
         sol_col_d = pos_col_d; // see RQ10
      end
   end

   // power led; transmit activity overrides steady green
   // supply loss wins: no orange is shown without power
   always_comb begin
      pwr_col_d = col_off;
      if (supply_5v_good) begin
         pwr_col_d = primary_serial_connector_tx ? col_orange : col_green; // see RQ21 RQ22
      end
   end

   // registered led drives
   // flops keep decode glitches off the panel drivers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         navigator_state_led <= col_off;
         solution_led <= col_off;
         power_led <= col_off;
      end else begin
         navigator_state_led <= nav_col_d;
         solution_led <= sol_col_d;
         power_led <= pwr_col_d;
      end
   end

endmodule

`default_nettype wire

// *** sim/nav_status_led_indicator_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module nav_status_led_indicator_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic program_running,
   input wire logic sleep_locked,
   input wire logic rx_data_active,
   input wire logic [2:0] pos_solution,
   input wire logic [2:0] head_solution,
   input wire logic supply_5v_good,
   input wire logic primary_serial_connector_tx,
   input wire logic [1:0] navigator_state_led,
   input wire logic [1:0] solution_led,
   input wire logic [1:0] power_led
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // the leds lag their cause by one registered cycle, two where the navigator state must step first
   AST_PWR_GREEN: assert property (
      supply_5v_good && !primary_serial_connector_tx |=> power_led == 2'h2) else $error("pwr");
   AST_PWR_TX: assert property (
      supply_5v_good && primary_serial_connector_tx |=> power_led == 2'h3) else $error("tx");
   AST_NAV_DARK: assert property (
      !program_running && navigator_state_led == 2'h0 |=> navigator_state_led == 2'h0)
      else $error("boot");
   // sleep shown only once booted, and never as off or orange
   AST_NAV_SLEEP: assert property (
      sleep_locked && $past(sleep_locked) && navigator_state_led != 2'h0
      |-> navigator_state_led inside {2'h1, 2'h2}) else $error("sleep");
   AST_NAV_GREEN: assert property (
      (!sleep_locked && navigator_state_led == 2'h2) [*2] |=> navigator_state_led == 2'h2)
      else $error("green");
   AST_SOL_DARK: assert property (
      !rx_data_active |=> solution_led == 2'h0) else $error("sol dark");
   AST_SOL_GREEN: assert property (
      rx_data_active && pos_solution == 3'h4 && head_solution == 3'h4
      |=> solution_led == 2'h2) else $error("sol green");
   AST_SOL_RED: assert property (
      rx_data_active && pos_solution == 3'h1 && head_solution == 3'h2
      |=> solution_led == 2'h1) else $error("sol red");
   cover property (!sleep_locked && navigator_state_led == 2'h2);
   cover property (sleep_locked && navigator_state_led == 2'h2);
   cover property (primary_serial_connector_tx && power_led == 2'h3);
endmodule
bind nav_status_led_indicator nav_status_led_indicator_assertions chk_inst (.aclk, .aresetn,
   .program_running, .sleep_locked, .rx_data_active, .pos_solution, .head_solution,
   .supply_5v_good, .primary_serial_connector_tx, .navigator_state_led, .solution_led,
   .power_led);
`default_nettype wire

// *** sim/led_panel_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module led_panel_model (
   input wire logic aclk,
   input wire logic clear,
   input wire logic [1:0] nav_led,
   input wire logic [1:0] sol_led,
   input wire logic [1:0] pwr_led,
   output logic [3:0] nav_seen,
   output logic [3:0] sol_seen,
   output logic [3:0] pwr_seen
);
   // an operator knows a blink only as the set of colours seen over time
   always_ff @(posedge aclk) begin
      nav_seen <= clear ? 4'h0 : nav_seen | (4'h1 << nav_led);
      sol_seen <= clear ? 4'h0 : sol_seen | (4'h1 << sol_led);
      pwr_seen <= clear ? 4'h0 : pwr_seen | (4'h1 << pwr_led);
   end
endmodule
`default_nettype wire

// *** sim/nav_status_led_indicator_tb.sv ***
`timescale 1ns/100ps
`include "led_ind_regs.svh"
`default_nettype none
module nav_status_led_indicator_tb;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, program_running = 0, sleep_locked = 0;
   logic int_time_lock = 0, ext_pos_vel_valid = 0, rx_data_active = 0, supply_5v_good = 0;
   logic primary_serial_connector_tx = 0, clear = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, nav_seen, sol_seen, pwr_seen;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [15:0] vehicle_speed = 0;
   logic [2:0] pos_solution = 0, head_solution = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, navigator_state_led, solution_led, power_led;
   int err_total = 0, n_checks = 0;
   always #2.5 aclk = ~aclk;
   nav_status_led_indicator #(.rt_cycles(32'h0000_012c)) nav_status_led_indicator_inst (.aclk,
      .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .program_running, .sleep_locked,
      .int_time_lock, .ext_pos_vel_valid, .vehicle_speed, .rx_data_active, .pos_solution,
      .head_solution, .supply_5v_good, .primary_serial_connector_tx, .navigator_state_led,
      .solution_led, .power_led);
   led_panel_model led_panel_model_inst (.aclk, .clear, .nav_led(navigator_state_led),
      .sol_led(solution_led), .pwr_led(power_led), .nav_seen, .sol_seen, .pwr_seen);
   task results;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
      @(posedge aclk);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, r);
      @(posedge aclk);
   endtask
   // settle, then watch two blink periods of 8 cycles
   task look;
      repeat (3) @(posedge aclk);
      clear <= 1'b1;
      @(posedge aclk);
      clear <= 1'b0;
      repeat (18) @(posedge aclk);
   endtask
   task sol(input logic [2:0] p, input logic [2:0] h, input logic [3:0] exp);
      pos_solution <= p;
      head_solution <= h;
      look;
      chk(sol_seen, exp);
   endtask
   // colour masks: off 1, red 2, green 4, orange 8
   task nav_walk;
      look;
      chk(nav_seen, 4'h1);
      program_running <= 1'b1;
      look;
      chk(nav_seen, 4'h3);
      sleep_locked <= 1'b1;
      look;
      chk(nav_seen, 4'h6);
      sleep_locked <= 1'b0;
      int_time_lock <= 1'b1;
      look;
      chk(nav_seen, 4'h9);
      ext_pos_vel_valid <= 1'b1;
      vehicle_speed <= 16'h000a;
      look;
      chk(nav_seen, 4'h2);
      vehicle_speed <= 16'h000b;
      look;
      chk(nav_seen, 4'h8);
      repeat (300) @(posedge aclk);
      look;
      chk(nav_seen, 4'h4);
      {int_time_lock, ext_pos_vel_valid} <= 2'b00;
      look;
      chk(nav_seen, 4'h4);
   endtask
   task sol_walk;
      look;
      chk(sol_seen, 4'h1);
      rx_data_active <= 1'b1;
      sol(3'h0, 3'h0, 4'h3);
      wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
      sol(3'h0, 3'h0, 4'h1);
      sol(3'h1, 3'h2, 4'h2);
      sol(3'h2, 3'h0, 4'h8);
      sol(3'h3, 3'h0, 4'h8);
      sol(3'h4, 3'h4, 4'h4);
      wr(`OFS_CTRL, 32'h3, `RESP_OKAY);
      sol(3'h4, 3'h0, 4'h3);
      sol(3'h4, 3'h2, 4'h2);
      sol(3'h4, 3'h3, 4'h8);
      sol(3'h4, 3'h4, 4'h4);
      rx_data_active <= 1'b0;
      look;
      chk(sol_seen, 4'h1);
   endtask
   task pwr_walk;
      chk(pwr_seen, 4'h1);
      supply_5v_good <= 1'b1;
      look;
      chk(pwr_seen, 4'h4);
      primary_serial_connector_tx <= 1'b1;
      look;
      chk(pwr_seen, 4'h8);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFS_BLINK, `BLINK_RST, `RESP_OKAY);
      wr(`OFS_BLINK, 32'h8, `RESP_OKAY);
      rd(`OFS_BLINK, 32'h8, `RESP_OKAY);
      wr(`OFS_SPEED, 32'ha, `RESP_OKAY);
      wr(`OFS_STATUS, 32'h0, `RESP_SLVERR);
      wr(4'h1, 32'h0, `RESP_SLVERR);
      rd(4'h1, 32'h0, `RESP_SLVERR);
      nav_walk;
      sol_walk;
      pwr_walk;
      rd(`OFS_STATUS, 32'h0000_00e5, `RESP_OKAY);
      results;
   end
   // cut a hang short well past the expected run of about 820 cycles
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      results;
   end
endmodule
`default_nettype wire
